// *** ref_edge_detect.sv ***
// synchroniser and active edge detector for the reference pin
`timescale 1ns/1ps
module ref_edge_detect (
  input  wire logic clock,
  input  wire logic sys_rst,
  input  wire logic ref_pin_in,
  input  wire logic rising_sel,
  ref_edge_if.src   edge_out
);
  logic s1_r;
  logic s2_r;
  logic s3_r;
  logic level_r;
  logic edge_r;
  wire  agree    = (s2_r == s3_r);
  wire  changed  = agree && (s3_r != level_r);
  wire  active   = rising_sel ? s3_r : ~s3_r;

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      s1_r    <= 1'b0;
      s2_r    <= 1'b0;
      s3_r    <= 1'b0;
      level_r <= 1'b0;
      edge_r  <= 1'b0;
    end else begin
      s1_r    <= ref_pin_in;
      s2_r    <= s1_r;
      s3_r    <= s2_r;
      level_r <= agree ? s3_r : level_r;
      edge_r  <= changed && active;
    end
  end

  assign edge_out.level     = level_r;
  assign edge_out.edge_seen = edge_r;
endmodule

// *** ref_edge_if.sv ***
// carries the filtered reference pin level and its active edge
`timescale 1ns/1ps
interface ref_edge_if;
  logic level;
  logic edge_seen;
  modport src (output level, output edge_seen);
  modport dst (input level, input edge_seen);
endinterface

// *** ref_source.sv ***
// external timing source that drives the reference pin
`timescale 1ns/1ps
module ref_source #(
  parameter int unsigned HIGH_CYC = 40
) (
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic fire,
  output logic      ref_level
);
  int cnt_r;
  // one pulse per request, idle low between pulses
  always_ff @(posedge clock or posedge rst)
    if (rst)
      cnt_r <= 0;
    else if (fire)
      cnt_r <= HIGH_CYC;
    else if (cnt_r != 0)
      cnt_r <= cnt_r - 1;
  assign ref_level = (cnt_r != 0);
endmodule

// *** sample_timing_checker.sv ***
// assertions on the ports of the sample timing block
`timescale 1ns/1ps
`include "sample_timing_params.svh"
module sample_timing_checker #(
  parameter int unsigned INT_SAMPLE_CYC = 20,
  parameter int unsigned AST_CYC        = 10
) (
  input wire logic        clock,
  input wire logic        sys_rst,
  input wire logic        wr_valid,
  input wire logic [15:0] wr_frame,
  input wire logic        rd_valid,
  input wire logic        rd_ack_r,
  input wire logic        data_valid_pin_r,
  input wire logic        ref_pin_oe_n_r,
  input wire logic        sample_strobe_r,
  input wire logic        st_actuate_r,
  input wire logic        cmd_busy_r,
  input wire logic        lin_accel_comp_en_r,
  input wire logic        percussion_align_en_r
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  logic [7:0] misc_lo_r;
  wire        misc_wr = wr_valid && wr_frame[15] && wr_frame[14:8] == `ADDR_MISC;
  // shadow of the low control byte
  always_ff @(posedge clock or posedge sys_rst)
    if (sys_rst)
      misc_lo_r <= 8'hc1;
    else if (misc_wr)
      misc_lo_r <= wr_frame[7:0];
  sequence s_start;
    wr_valid && wr_frame == 16'hbe04 && !cmd_busy_r;
  endsequence
  sequence s_run;
    cmd_busy_r && st_actuate_r;
  endsequence
  property p_start;
    s_start |-> ##[1:2] s_run;
  endproperty
  a_start: assert property (p_start)
    else $error("self test did not start");
  property p_busy_hold;
    $rose(cmd_busy_r) |-> cmd_busy_r[*8];
  endproperty
  a_busy_hold: assert property (p_busy_hold)
    else $error("self test ended early");
  property p_busy_end;
    $rose(cmd_busy_r) |-> ##[8:40] !cmd_busy_r;
  endproperty
  a_busy_end: assert property (p_busy_end)
    else $error("self test never resumed");
  property p_quiet;
    cmd_busy_r |-> !sample_strobe_r;
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("output load while busy");
  property p_dv_busy;
    cmd_busy_r && $past(cmd_busy_r) |-> data_valid_pin_r == !misc_lo_r[0];
  endproperty
  a_dv_busy: assert property (p_dv_busy)
    else $error("data valid active while busy");
  property p_dv_load;
    sample_strobe_r && $stable(misc_lo_r) |-> ##[0:2] data_valid_pin_r == misc_lo_r[0];
  endproperty
  a_dv_load: assert property (p_dv_load)
    else $error("no data valid after load");
  property p_oe;
    misc_lo_r[3:2] != 2'b11 && $stable(misc_lo_r) |-> ref_pin_oe_n_r;
  endproperty
  a_oe: assert property (p_oe)
    else $error("reference pin driven outside indicator mode");
  property p_comp;
    $stable(misc_lo_r) |->
      lin_accel_comp_en_r == misc_lo_r[7] && percussion_align_en_r == misc_lo_r[6];
  endproperty
  a_comp: assert property (p_comp)
    else $error("compensation enables wrong");
  property p_ack;
    rd_valid |=> rd_ack_r;
  endproperty
  a_ack: assert property (p_ack)
    else $error("read not answered");
endmodule
bind sample_timing_ctrl sample_timing_checker #(
  .INT_SAMPLE_CYC(INT_SAMPLE_CYC),
  .AST_CYC       (AST_CYC)
) u_chk (.*);

// *** sample_timing_ctrl.sv ***
// sample clock selection, decimation, data valid pin and automated self test
//
// Behaviour
// - gcmd bit 2 write halts output, actuates sensor self test, checks, resumes.
// - self test outcome lands in diag status bit 5, one meaning fail.
// - data valid pin signals each load of fresh output results.
// - misc bit 0 one makes data valid active high, zero active low.
// - no data valid indication while a global command runs.
// - misc bits 3:2 pick internal, direct, scaled or indicator reference mode.
// - misc bit 1 picks rising or falling reference edge in direct, scaled and indicator modes.
// - misc bits 7 and 6 enable accel compensation and percussion alignment.
// - misc control resets to 0x00c1.
// - indicator mode samples internally and pulses reference pin at sample time.
// - scaled mode update rate is reference frequency times scale factor.
// - on lock loss stop following reference and set diag status bit 7.
// - scale factor is 15 bits, bit 15 unused, resets to 0x7fff.
// - scaled mode age counter runs at 24576 Hz, cleared on reference edge.
// - direct mode updates output on each active reference edge.
// - internal clock makes samples at 2048 per second before decimation.
// - decimation d in bits 10:0 divides update rate by d plus one.
// - diag status read returns flags then clears; persisting flags set again.
`timescale 1ns/1ps
`include "sample_timing_params.svh"
module sample_timing_ctrl
  import sample_timing_pkg::*;
#(
  parameter int unsigned INT_SAMPLE_CYC = `CLK_HZ / `INT_SPS,
  parameter int unsigned AST_CYC        = `AST_TIME_MS * (`CLK_HZ / 1000)
) (
  input  wire logic        clock,
  input  wire logic        sys_rst,
  input  wire logic        wr_valid,
  input  wire logic [15:0] wr_frame,
  input  wire logic        rd_valid,
  input  wire logic [6:0]  rd_addr,
  input  wire logic        ref_pin_in,
  input  wire logic        st_response_ok,
  output logic [15:0]      rd_data_r,
  output logic             rd_ack_r,
  output logic             data_valid_pin_r,
  output logic             ref_pin_out_r,
  output logic             ref_pin_oe_n_r,
  output logic             sample_strobe_r,
  output logic             st_actuate_r,
  output logic             cmd_busy_r,
  output logic             lin_accel_comp_en_r,
  output logic             percussion_align_en_r
);
  if (INT_SAMPLE_CYC < 2 || AST_CYC < 2) begin : g_bad_param
    $error("cycle counts must be at least two");
  end

  // register file
  logic [15:0] misc_r;
  logic [15:0] scale_r;
  logic [15:0] dec_r;
  logic [15:0] age_r;
  logic        diag_ast_r;
  logic        diag_lock_r;

  ref_edge_if ref_edge ();

  ref_edge_detect u_edge (
    .clock      (clock),
    .sys_rst    (sys_rst),
    .ref_pin_in (ref_pin_in),
    .rising_sel (misc_r[`MISC_REF_EDGE]),
    .edge_out   (ref_edge.src)
  );

  // serial write decode, one byte per frame
  wire       wr_en    = wr_valid && wr_frame[`FRAME_WR_BIT];
  wire [6:0] wr_addr  = wr_frame[`FRAME_ADDR_HI:`FRAME_ADDR_LO];
  wire [7:0] wr_byte  = wr_frame[7:0];
  wire [5:0] wr_word  = wr_addr[6:1];
  wire       wr_hi    = wr_addr[0];
  wire       wr_misc  = wr_en && (wr_word == `ADDR_MISC >> 1);
  wire       wr_scale = wr_en && (wr_word == `ADDR_SCALE >> 1);
  wire       wr_dec   = wr_en && (wr_word == `ADDR_DEC >> 1);
  wire       wr_age   = wr_en && (wr_word == `ADDR_AGE >> 1);
  wire       wr_gcmd  = wr_en && (wr_addr == `ADDR_GCMD);

  function automatic logic [15:0] put_byte(input logic [15:0] old, input logic hi,
                                           input logic [7:0] b, input logic [15:0] mask);
    logic [15:0] v;
    v = hi ? {b, old[7:0]} : {old[15:8], b};
    return v & mask;
  endfunction

  // (low byte and high byte frames land separately)
  wire [15:0] misc_nxt  = wr_misc  ? put_byte(misc_r, wr_hi, wr_byte, `MISC_MASK) : misc_r;
  wire [15:0] scale_nxt = wr_scale ? put_byte(scale_r, wr_hi, wr_byte, `SCALE_MASK) : scale_r;
  wire [15:0] dec_nxt   = wr_dec   ? put_byte(dec_r, wr_hi, wr_byte, `DEC_MASK) : dec_r;

  ref_mode_e mode;
  assign mode = ref_mode_e'(misc_r[`MISC_MODE_HI:`MISC_MODE_LO]);
  wire dv_pol   = misc_r[`MISC_DV_POL];
  wire edge_pol = misc_r[`MISC_REF_EDGE];

  // self test sequencer
  ast_state_e  ast_state_r;
  ast_state_e  ast_state_nxt;
  logic [31:0] ast_cnt_r;
  wire ast_start = wr_gcmd && wr_byte[`GCMD_AST];
  wire ast_done  = (ast_state_r == ast_check);
  wire busy      = (ast_state_r != ast_idle);

  always_comb begin
    ast_state_nxt = ast_state_r;
    case (ast_state_r)
      ast_idle:  if (ast_start) ast_state_nxt = ast_run;
      ast_run:   if (ast_cnt_r == 32'h0000_0000) ast_state_nxt = ast_check;
      ast_check: ast_state_nxt = ast_idle;
      default:   ast_state_nxt = ast_idle;
    endcase
  end

  wire [31:0] ast_cnt_nxt = (ast_state_r == ast_idle) ? 32'(AST_CYC - 1) :
                            (ast_cnt_r == 32'h0000_0000) ? ast_cnt_r : ast_cnt_r - 32'd1;

  // internal 2048 per second sample clock
  logic [31:0] int_cnt_r;
  wire         int_tick    = (int_cnt_r == 32'(INT_SAMPLE_CYC - 1));
  wire [31:0]  int_cnt_nxt = int_tick ? 32'h0000_0000 : int_cnt_r + 32'd1;

  // reference period measurement for scaled mode
  logic [31:0] per_cnt_r;
  logic [31:0] period_r;
  logic        period_seen_r;
  wire ref_edge_hit = ref_edge.edge_seen;
  wire [31:0] per_cnt_nxt = ref_edge_hit ? 32'h0000_0000 :
                            (&per_cnt_r) ? per_cnt_r : per_cnt_r + 32'd1;
  wire [31:0] period_nxt  = ref_edge_hit ? per_cnt_r + 32'd1 : period_r;
  wire [31:0] period_meas = (per_cnt_r > period_r) ? per_cnt_r : period_r;

  // lock window: min <= scale * clk / period <= max
  wire [47:0] rate_num = 48'(scale_r[14:0]) * 48'(`CLK_HZ);
  wire [47:0] min_lim  = 48'(period_meas) * 48'(`LOCK_MIN_HZ);
  wire [47:0] max_lim  = 48'(period_meas) * 48'(`LOCK_MAX_HZ);
  wire lock_ok   = (rate_num >= min_lim) && (rate_num <= max_lim);
  wire scaled    = (mode == mode_scaled);
  wire lock_lost = scaled && period_seen_r && !lock_ok;
  wire follow    = scaled && period_seen_r && lock_ok;

  // phase accumulator: scale ticks per reference period
  logic [32:0] acc_r;
  wire [32:0] acc_sum  = acc_r + 33'(scale_r[14:0]);
  wire        acc_tick = follow && (acc_sum >= 33'(period_r));
  wire [32:0] acc_nxt  = !follow || ref_edge_hit ? 33'h0_0000_0000 :
                         acc_tick ? acc_sum - 33'(period_r) : acc_sum;

  // raw sample source per mode
  logic raw_sample;
  always_comb begin
    case (mode)
      mode_direct: raw_sample = ref_edge_hit;
      mode_scaled: raw_sample = follow ? acc_tick : int_tick;
      default:     raw_sample = int_tick;
    endcase
  end
  wire halt      = busy || ast_start;
  wire sample_ok = raw_sample && !halt;

  // decimation
  logic [10:0] dec_cnt_r;
  wire dec_hit   = (dec_cnt_r >= dec_r[10:0]);
  wire out_load  = sample_ok && dec_hit;
  wire [10:0] dec_cnt_nxt = busy ? 11'h000 : !sample_ok ? dec_cnt_r :
                            dec_hit ? 11'h000 : dec_cnt_r + 11'd1;

  // data valid pulse
  logic [7:0] dv_cnt_r;
  wire [7:0] dv_cnt_nxt = halt ? 8'h00 : out_load ? 8'(`DV_PULSE_CYC) :
                          (dv_cnt_r != 8'h00) ? dv_cnt_r - 8'd1 : dv_cnt_r;
  wire dv_active = (dv_cnt_nxt != 8'h00);
  wire dv_pin    = ~(dv_active ^ dv_pol);

  // sample time indicator output
  logic [7:0] ind_cnt_r;
  wire indicator = (mode == mode_indicator);
  wire [7:0] ind_cnt_nxt = (indicator && int_tick) ? 8'(`IND_PULSE_CYC) :
                           (ind_cnt_r != 8'h00) ? ind_cnt_r - 8'd1 : ind_cnt_r;
  wire ind_pin = ~((ind_cnt_nxt != 8'h00) ^ edge_pol);

  // sample age counter
  logic [15:0] age_tick_r;
  wire age_tick = (age_tick_r == 16'(`AGE_CYC - 1));
  wire [15:0] age_tick_nxt = (age_tick || ref_edge_hit) ? 16'h0000 : age_tick_r + 16'd1;
  wire [15:0] age_nxt = (scaled && ref_edge_hit) ? 16'h0000 :
                        (scaled && age_tick) ? age_r + 16'd1 :
                        wr_age ? put_byte(age_r, wr_hi, wr_byte, 16'hffff) : age_r;

  // diagnostic flags: read clears, a set in the same cycle wins
  wire rd_diag  = rd_valid && (rd_addr == `ADDR_DIAG);
  wire ast_fail = ast_done && !st_response_ok;
  wire diag_ast_nxt  = ast_done ? ast_fail : (rd_diag ? 1'b0 : diag_ast_r);
  wire diag_lock_nxt = (lock_lost && int_tick) ? 1'b1 :
                       (rd_diag ? 1'b0 : diag_lock_r);

  // read mux
  logic [15:0] rd_mux;
  always_comb begin
    case (rd_addr)
      `ADDR_DIAG:  rd_mux = {8'h00, diag_lock_r, 1'b0, diag_ast_r, 5'h00};
      `ADDR_AGE:   rd_mux = age_r;
      `ADDR_MISC:  rd_mux = misc_r;
      `ADDR_SCALE: rd_mux = scale_r;
      `ADDR_DEC:   rd_mux = dec_r;
      default:     rd_mux = 16'h0000;
    endcase
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      misc_r  <= `MISC_RST;
      scale_r <= `SCALE_RST;
      dec_r   <= `DEC_RST;
    end else begin
      misc_r  <= misc_nxt;
      scale_r <= scale_nxt;
      dec_r   <= dec_nxt;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      ast_state_r  <= ast_idle;
      ast_cnt_r    <= 32'h0000_0000;
      st_actuate_r <= 1'b0;
      cmd_busy_r   <= 1'b0;
      diag_ast_r   <= 1'b0;
      diag_lock_r  <= 1'b0;
    end else begin
      ast_state_r  <= ast_state_nxt;
      ast_cnt_r    <= ast_cnt_nxt;
      st_actuate_r <= (ast_state_nxt == ast_run);
      cmd_busy_r   <= (ast_state_nxt != ast_idle);
      diag_ast_r   <= diag_ast_nxt;
      diag_lock_r  <= diag_lock_nxt;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      int_cnt_r     <= 32'h0000_0000;
      per_cnt_r     <= 32'h0000_0000;
      period_r      <= 32'h0000_0000;
      period_seen_r <= 1'b0;
      acc_r         <= 33'h0_0000_0000;
      age_tick_r    <= 16'h0000;
      age_r         <= 16'h0000;
    end else begin
      int_cnt_r     <= int_cnt_nxt;
      per_cnt_r     <= per_cnt_nxt;
      period_r      <= period_nxt;
      period_seen_r <= scaled && (period_seen_r || ref_edge_hit);
      acc_r         <= acc_nxt;
      age_tick_r    <= age_tick_nxt;
      age_r         <= age_nxt;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      dec_cnt_r        <= 11'h000;
      dv_cnt_r         <= 8'h00;
      ind_cnt_r        <= 8'h00;
      sample_strobe_r  <= 1'b0;
      data_valid_pin_r <= 1'b0;
      ref_pin_out_r    <= 1'b0;
      ref_pin_oe_n_r   <= 1'b1;
    end else begin
      dec_cnt_r        <= dec_cnt_nxt;
      dv_cnt_r         <= dv_cnt_nxt;
      ind_cnt_r        <= ind_cnt_nxt;
      sample_strobe_r  <= out_load;
      data_valid_pin_r <= dv_pin;
      ref_pin_out_r    <= ind_pin;
      ref_pin_oe_n_r   <= ~indicator;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      rd_data_r <= 16'h0000;
      rd_ack_r  <= 1'b0;
    end else begin
      rd_data_r <= rd_valid ? rd_mux : rd_data_r;
      rd_ack_r  <= rd_valid;
    end
  end

  assign lin_accel_comp_en_r   = misc_r[`MISC_LINACC];
  assign percussion_align_en_r = misc_r[`MISC_POP];
endmodule

// *** sample_timing_params.svh ***
// constants for the sample timing and self test block
`ifndef SAMPLE_TIMING_PARAMS_SVH
`define SAMPLE_TIMING_PARAMS_SVH
`define ADDR_DIAG      7'h02
`define ADDR_AGE       7'h1c
`define ADDR_MISC      7'h32
`define ADDR_SCALE     7'h34
`define ADDR_DEC       7'h36
`define ADDR_GCMD      7'h3e
`define FRAME_WR_BIT   15
`define FRAME_ADDR_HI  14
`define FRAME_ADDR_LO  8
`define MISC_DV_POL    0
`define MISC_REF_EDGE  1
`define MISC_MODE_LO   2
`define MISC_MODE_HI   3
`define MISC_POP       6
`define MISC_LINACC    7
`define GCMD_AST       2
`define DIAG_AST       5
`define DIAG_LOCK      7
`define MISC_RST       16'h00c1
`define SCALE_RST      16'h7fff
`define DEC_RST        16'h0000
`define MISC_MASK      16'h00cf
`define SCALE_MASK     16'h7fff
`define DEC_MASK       16'h07ff
`define CLK_HZ         100000000
`define INT_SPS        2048
`define AGE_HZ         24576
`define AST_TIME_MS    7
`define LOCK_MIN_HZ    1945
`define LOCK_MAX_HZ    2048
`define DV_PULSE_CYC   16
`define IND_PULSE_CYC  16
`define AGE_CYC        (`CLK_HZ / `AGE_HZ)
`endif

// *** sample_timing_pkg.sv ***
// types for the sample timing and self test block
package sample_timing_pkg;
  typedef enum logic [1:0] {
    mode_internal  = 2'b00,
    mode_direct    = 2'b01,
    mode_scaled    = 2'b10,
    mode_indicator = 2'b11
  } ref_mode_e;
  typedef enum logic [2:0] {
    ast_idle  = 3'b001,
    ast_run   = 3'b010,
    ast_check = 3'b100
  } ast_state_e;
endpackage

// *** tb_sample_timing_and_self_test_control.sv ***
// self-checking bench for the sample timing and self test block
`timescale 1ns/1ps
`include "sample_timing_params.svh"
module tb_sample_timing_and_self_test_control;
  logic        clock    = 1'b0;
  logic        sys_rst  = 1'b1;
  logic        wr_valid = 1'b0;
  logic [15:0] wr_frame = 16'h0000;
  logic        rd_valid = 1'b0;
  logic [6:0]  rd_addr  = 7'h00;
  logic        st_ok    = 1'b1;
  logic        fire     = 1'b0;
  logic [15:0] rd_data;
  logic        rd_ack, dv, ref_out, oe_n, strobe, st_act, busy, lin_en, pop_en;
  logic        ref_level;
  wire         ref_pin = !oe_n ? ref_out : ref_level;
  int          n_errors = 0;
  int          n_checks = 0;
  sample_timing_ctrl #(.INT_SAMPLE_CYC(20), .AST_CYC(10)) u_dut (
    .clock(clock), .sys_rst(sys_rst), .wr_valid(wr_valid), .wr_frame(wr_frame),
    .rd_valid(rd_valid), .rd_addr(rd_addr), .ref_pin_in(ref_pin),
    .st_response_ok(st_ok), .rd_data_r(rd_data), .rd_ack_r(rd_ack),
    .data_valid_pin_r(dv), .ref_pin_out_r(ref_out), .ref_pin_oe_n_r(oe_n),
    .sample_strobe_r(strobe), .st_actuate_r(st_act), .cmd_busy_r(busy),
    .lin_accel_comp_en_r(lin_en), .percussion_align_en_r(pop_en));
  ref_source u_ref (.clock(clock), .rst(sys_rst), .fire(fire), .ref_level(ref_level));
  initial forever #5 clock = ~clock;
  task automatic end_sim();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge clock);
    wr_valid <= 1'b1;
    wr_frame <= {1'b1, a, d};
    @(posedge clock);
    wr_valid <= 1'b0;
  endtask
  task automatic wr16(input logic [6:0] a, input logic [15:0] v);
    wr(a, v[7:0]);
    wr(a + 7'h01, v[15:8]);
  endtask
  task automatic rdc(input logic [6:0] a, input logic [15:0] e);
    @(posedge clock);
    rd_valid <= 1'b1;
    rd_addr  <= a;
    @(posedge clock);
    rd_valid <= 1'b0;
    #1;
    chk({15'h0000, rd_ack}, 16'h0001);
    chk(rd_data, e);
  endtask
  task automatic wait_on(input int sel, input int lim);
    for (int i = 0; i < lim; i++) begin
      @(posedge clock);
      #1;
      if ((sel == 0 && strobe === 1'b1) || (sel == 1 && busy === 1'b1) ||
          (sel == 2 && busy === 1'b0))
        return;
    end
    n_errors++;
    $display("BAD %0t wait ran out", $time);
    end_sim();
  endtask
  task automatic count_strobes(input int cyc, output int n);
    n = 0;
    repeat (cyc) begin
      @(posedge clock);
      #1;
      if (strobe === 1'b1)
        n++;
    end
  endtask
  task automatic pulse();
    @(posedge clock);
    fire <= 1'b1;
    @(posedge clock);
    fire <= 1'b0;
  endtask
  task automatic t_reset();
    rdc(`ADDR_MISC, 16'h00c1);
    rdc(`ADDR_SCALE, 16'h7fff);
    rdc(`ADDR_DEC, 16'h0000);
    rdc(`ADDR_DIAG, 16'h0000);
    rdc(7'h10, 16'h0000);
  endtask
  task automatic t_masks();
    wr16(`ADDR_MISC, 16'hffcf);
    rdc(`ADDR_MISC, 16'h00cf);
    chk({14'h0000, lin_en, pop_en}, 16'h0003);
    wr16(`ADDR_MISC, 16'h0000);
    repeat (2) @(posedge clock);
    #1;
    chk({14'h0000, lin_en, pop_en}, 16'h0000);
    wr16(`ADDR_SCALE, 16'hffff);
    rdc(`ADDR_SCALE, 16'h7fff);
    wr16(`ADDR_DEC, 16'hffff);
    rdc(`ADDR_DEC, 16'h07ff);
  endtask
  task automatic t_internal(input logic [10:0] d, input logic [7:0] m);
    time t0;
    wr16(`ADDR_DEC, {5'h00, d});
    wr(`ADDR_MISC, m);
    wait_on(0, 200);
    wait_on(0, 200);
    t0 = $time;
    wait_on(0, 200);
    chk(16'(($time - t0) / 10), 16'((d + 11'd1) * 20));
    repeat (3) @(posedge clock);
    #1;
    chk({15'h0000, dv}, {15'h0000, m[0]});
    repeat (15) @(posedge clock);
    #1;
    chk({15'h0000, dv}, {15'h0000, ~m[0]});
  endtask
  task automatic t_indicator(input logic [7:0] m);
    wr(`ADDR_MISC, m);
    wait_on(0, 100);
    wait_on(0, 100);
    chk({15'h0000, oe_n}, 16'h0000);
    repeat (2) @(posedge clock);
    #1;
    chk({15'h0000, ref_out}, {15'h0000, m[1]});
    repeat (16) @(posedge clock);
    #1;
    chk({15'h0000, ref_out}, {15'h0000, ~m[1]});
  endtask
  task automatic t_direct(input logic [7:0] m);
    int n;
    wr(`ADDR_MISC, m);
    count_strobes(40, n);
    pulse();
    count_strobes(30, n);
    chk(16'(n), {15'h0000, m[1]});
    count_strobes(40, n);
    chk(16'(n), {15'h0000, ~m[1]});
  endtask
  task automatic t_age();
    wr(`ADDR_MISC, 8'hc9);
    wr16(`ADDR_SCALE, 16'h7fff);
    wr16(`ADDR_AGE, 16'h1234);
    pulse();
    repeat (60) @(posedge clock);
    rdc(`ADDR_AGE, 16'h0000);
    repeat (25) @(posedge clock);
    wr(`ADDR_MISC, 8'hc1);
    rdc(`ADDR_DIAG, 16'h0080);
    rdc(`ADDR_DIAG, 16'h0000);
  endtask
  task automatic t_midreset();
    wr16(`ADDR_DEC, 16'h0005);
    wr(`ADDR_MISC, 8'h0c);
    @(posedge clock);
    sys_rst <= 1'b1;
    repeat (3) @(posedge clock);
    sys_rst <= 1'b0;
    t_reset();
  endtask
  task automatic t_selftest(input logic ok);
    int n;
    wr(`ADDR_MISC, 8'hc1);
    rdc(`ADDR_DIAG, 16'h0000);
    st_ok <= ok;
    wr(`ADDR_GCMD, 8'h04);
    wait_on(1, 5);
    chk({15'h0000, st_act}, 16'h0001);
    count_strobes(8, n);
    chk(16'(n), 16'h0000);
    wait_on(2, 40);
    rdc(`ADDR_DIAG, {10'h000, ~ok, 5'h00});
    rdc(`ADDR_DIAG, 16'h0000);
  endtask
  initial begin
    repeat (16) @(posedge clock);
    sys_rst <= 1'b0;
    t_reset();
    t_masks();
    t_internal(11'd2, 8'hc0);
    t_internal(11'd0, 8'hc1);
    t_indicator(8'hcd);
    t_indicator(8'hcf);
    t_direct(8'hc5);
    t_direct(8'hc7);
    t_age();
    t_selftest(1'b0);
    t_selftest(1'b1);
    t_midreset();
    end_sim();
  end
  initial begin
    #100000;
    n_errors++;
    $display("BAD %0t run too long", $time);
    end_sim();
  end
endmodule
